// File: pkg/rxsb_defines.svh
// constants of the receive segmented user bus block
// assumes a single 20 MHz clock and an async active-low reset
//
// Operation
// - each segment carries 128 data bits that mean something only while its enable is high.
// - a segment's enable qualifies all its other signals, which the consumer ignores otherwise.
// - the first flag is 1 on the first transfer of a packet and only counts with enable.
// - there are four independent segments, each with data, enable and first flag.
// - pll lock in and pll reset out are 3 bits for ten lanes, 1 bit for four, selected pll only.
// - the last flag is 1 on the final transfer of a packet and only counts with enable.
// - the error flag is 1 for a packet in error, 0 otherwise, and counts with enable and last.
// - the 4-bit empty count holds unused bytes of the last transfer, low 3 bits 000 on error.
`ifndef RXSB_DEFINES_SVH
`define RXSB_DEFINES_SVH

// ****************************************
// bus shape
// ****************************************
`define RXSB_SEG_COUNT 4
`define RXSB_DATA_W 128
`define RXSB_EMPTY_W 4
`define RXSB_ERR_EMPTY_LOW 3'h0
`define RXSB_FILL_W 3

// ****************************************
// pll port widths per lane mode
// ****************************************
`define RXSB_CLK_W_TEN 10
`define RXSB_CLK_W_FOUR 4
`define RXSB_LOCK_W_TEN 3
`define RXSB_LOCK_W_FOUR 1

// ****************************************
// timing
// ****************************************
`define RXSB_CLK_MHZ 20
`define RXSB_RST_HOLD_NS 1000
`define RXSB_RST_HOLD_CYC ((`RXSB_RST_HOLD_NS * `RXSB_CLK_MHZ + 999) / 1000)
`define RXSB_HOLD_CNT_W 8

`endif

// File: pkg/rxsb_pkg.sv
// types of the receive segmented user bus block
// assumes rxsb_defines.svh is on the include path
`include "rxsb_defines.svh"

package rxsb_pkg;

  typedef logic [`RXSB_DATA_W-1:0] rxsb_data_t;
  typedef logic [`RXSB_EMPTY_W-1:0] rxsb_empty_t;
  typedef logic [`RXSB_LOCK_W_TEN-1:0] rxsb_lock_t;

  // one 16-byte transfer with its packet marks
  typedef struct packed {
    rxsb_data_t data;
    logic first;
    logic last;
    logic error;
    rxsb_empty_t empty;
  } rxsb_chunk_t;

  // registered state of one output segment
  typedef struct packed {
    logic ena;
    rxsb_chunk_t chunk;
  } rxsb_seg_state_t;

  // pll reset sequencer, one-hot
  typedef enum logic [2:0] {
    RXSB_PR_HOLD = 3'h1,
    RXSB_PR_WAIT = 3'h2,
    RXSB_PR_RUN = 3'h4
  } rxsb_pll_state_t;

  typedef struct packed {
    rxsb_pll_state_t pst;
    logic [`RXSB_HOLD_CNT_W-1:0] hold_cnt;
    rxsb_lock_t lock_a_s1;
    rxsb_lock_t lock_a_s2;
    rxsb_lock_t lock_b_s1;
    rxsb_lock_t lock_b_s2;
    rxsb_lock_t rst_a;
    rxsb_lock_t rst_b;
    logic ready;
    logic [`RXSB_FILL_W-1:0] cnt;
    rxsb_chunk_t [`RXSB_SEG_COUNT-1:0] slots;
  } rxsb_top_state_t;

endpackage

// File: pkg/rxsb_seg_if.sv
// carrier between the packer and one segment output stage
// assumes rxsb_pkg is compiled first
`timescale 1ns/1ps
`default_nettype none

interface rxsb_seg_if;
  logic ena;
  rxsb_pkg::rxsb_chunk_t chunk;
  modport src (output ena, output chunk);
  modport dst (input ena, input chunk);
endinterface

`default_nettype wire

// File: rtl/rxsb_seg_format.sv
// one output segment: registers and cleans a transfer for the user bus
// assumes link signals come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "rxsb_defines.svh"

module rxsb_seg_format (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // from the packer
  rxsb_seg_if.dst link,
  // segment outputs
  output logic ena,
  output rxsb_pkg::rxsb_data_t data,
  output logic first,
  output logic last,
  output logic error,
  output rxsb_pkg::rxsb_empty_t empty
);
  import rxsb_pkg::*;

  rxsb_seg_state_t r;
  rxsb_seg_state_t nxt;

  // flags forced low off-enable so a careless consumer never sees stale marks
  always_comb begin
    nxt = r;
    nxt.ena = link.ena;
    nxt.chunk.data = link.ena ? link.chunk.data : '0;
    nxt.chunk.first = link.ena & link.chunk.first;
    nxt.chunk.last = link.ena & link.chunk.last;
    nxt.chunk.error = link.ena & link.chunk.last & link.chunk.error;
    nxt.chunk.empty = '0;
    if (link.ena && link.chunk.last) begin
      if (link.chunk.error) begin
        nxt.chunk.empty = {link.chunk.empty[`RXSB_EMPTY_W-1], `RXSB_ERR_EMPTY_LOW};
      end else begin
        nxt.chunk.empty = link.chunk.empty;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= nxt;
    end
  end

  assign ena = r.ena;
  assign data = r.chunk.data;
  assign first = r.chunk.first;
  assign last = r.chunk.last;
  assign error = r.chunk.error;
  assign empty = r.chunk.empty;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_seg_quiet: assert property (!ena |-> (data == '0) && !first && !last && !error)
    else $error("segment drives data or flags while disabled");
  a_err_empty: assert property (error |-> last && ena && (empty[2:0] == 3'h0))
    else $error("error transfer has nonzero low empty bits");
  a_data_carry: assert property (link.ena |=> ena && (data == $past(link.chunk.data)))
    else $error("segment data not carried from packer");

endmodule

`default_nettype wire

// File: rtl/rxsb_rx_bus.sv
// receive segmented user bus: packs received transfers onto four segments
// assumes the transfer stream comes from mac logic on this clock; pll lock pins are async
`timescale 1ns/1ps
`default_nettype none
`include "rxsb_defines.svh"

module rxsb_rx_bus #(
  parameter bit TEN_LANE = 1'b1,
  parameter bit PLL_SEL = 1'b0,
  localparam int CLK_W = TEN_LANE ? `RXSB_CLK_W_TEN : `RXSB_CLK_W_FOUR,
  localparam int LOCK_W = TEN_LANE ? `RXSB_LOCK_W_TEN : `RXSB_LOCK_W_FOUR
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // received transfers from the mac
  input wire logic in_valid,
  input wire rxsb_pkg::rxsb_data_t in_data,
  input wire logic in_first,
  input wire logic in_last,
  input wire logic in_error,
  input wire rxsb_pkg::rxsb_empty_t in_empty,
  // transceiver pll clocks from shared logic
  input wire logic [CLK_W-1:0] pll_a_clock_input,
  input wire logic [CLK_W-1:0] pll_a_reference_clock_input,
  input wire logic [CLK_W-1:0] pll_b_clock_input,
  input wire logic [CLK_W-1:0] pll_b_reference_clock_input,
  // transceiver pll lock and reset
  input wire logic [LOCK_W-1:0] pll_a_lock_input,
  input wire logic [LOCK_W-1:0] pll_b_lock_input,
  output logic [LOCK_W-1:0] pll_a_reset_output,
  output logic [LOCK_W-1:0] pll_b_reset_output,
  // status
  output logic rx_link_ready,
  // segmented user bus
  output wire rxsb_pkg::rxsb_data_t [`RXSB_SEG_COUNT-1:0] rx_segment_data,
  output wire logic [`RXSB_SEG_COUNT-1:0] rx_segment_valid_enable,
  output wire logic [`RXSB_SEG_COUNT-1:0] rx_segment_first_flag,
  output wire logic [`RXSB_SEG_COUNT-1:0] rx_segment_last_flag,
  output wire logic [`RXSB_SEG_COUNT-1:0] rx_segment_error_flag,
  output wire rxsb_pkg::rxsb_empty_t [`RXSB_SEG_COUNT-1:0] rx_segment_empty_count
);
  import rxsb_pkg::*;

  // ****************************************
  // constants
  // ****************************************
  localparam int HOLD_CYC = `RXSB_RST_HOLD_CYC;
  localparam logic [`RXSB_HOLD_CNT_W-1:0] HOLD_LAST = `RXSB_HOLD_CNT_W'(HOLD_CYC - 1);
  localparam rxsb_lock_t RST_ON = '1;
  localparam rxsb_lock_t RST_OFF = '0;
  localparam rxsb_top_state_t RST_STATE = '{
    pst: RXSB_PR_HOLD,
    rst_a: PLL_SEL ? RST_OFF : RST_ON,
    rst_b: PLL_SEL ? RST_ON : RST_OFF,
    default: '0
  };

  rxsb_top_state_t r;
  rxsb_top_state_t nxt;
  rxsb_lock_t lock_a_ext;
  rxsb_lock_t lock_b_ext;
  rxsb_lock_t lock_sel;
  rxsb_chunk_t in_chunk;
  rxsb_chunk_t [`RXSB_SEG_COUNT-1:0] view;
  logic [`RXSB_FILL_W-1:0] vcnt;
  logic lock_ok;
  logic accept;
  logic flush;

  // ****************************************
  // lock widening
  // ****************************************

  // absent lock bits read as locked so the one and three bit lock widths share the sync
  always_comb begin
    lock_a_ext = RST_ON;
    lock_b_ext = RST_ON;
    lock_a_ext[LOCK_W-1:0] = pll_a_lock_input;
    lock_b_ext[LOCK_W-1:0] = pll_b_lock_input;
  end

  assign in_chunk = '{data: in_data, first: in_first, last: in_last, error: in_error,
                      empty: in_empty};

  // ****************************************
  // sequencer and packer
  // ****************************************

  // next state: pll reset sequencing, then filling segments low to high
  always_comb begin
    nxt = r;
    nxt.lock_a_s1 = lock_a_ext;
    nxt.lock_a_s2 = r.lock_a_s1;
    nxt.lock_b_s1 = lock_b_ext;
    nxt.lock_b_s2 = r.lock_b_s1;
    lock_sel = PLL_SEL ? r.lock_b_s2 : r.lock_a_s2;
    lock_ok = &lock_sel;
    unique case (r.pst)
      RXSB_PR_HOLD: begin
        if (r.hold_cnt == HOLD_LAST) begin
          nxt.pst = RXSB_PR_WAIT;
          nxt.hold_cnt = '0;
        end else begin
          nxt.hold_cnt = r.hold_cnt + `RXSB_HOLD_CNT_W'(1);
        end
      end
      RXSB_PR_WAIT: begin
        if (lock_ok) begin
          nxt.pst = RXSB_PR_RUN;
        end
      end
      RXSB_PR_RUN: begin
        // lost lock restarts the pll; a packet in flight is cut short
        if (!lock_ok) begin
          nxt.pst = RXSB_PR_HOLD;
        end
      end
      default: begin
        nxt.pst = RXSB_PR_HOLD;
        nxt.hold_cnt = '0;
      end
    endcase
    // only the selected pll sees a reset pulse
    nxt.rst_a = (!PLL_SEL && nxt.pst == RXSB_PR_HOLD) ? RST_ON : RST_OFF;
    nxt.rst_b = (PLL_SEL && nxt.pst == RXSB_PR_HOLD) ? RST_ON : RST_OFF;
    nxt.ready = (nxt.pst == RXSB_PR_RUN);
    // transfers only flow once the pll is up
    accept = in_valid && (r.pst == RXSB_PR_RUN);
    view = r.slots;
    vcnt = r.cnt;
    if (accept) begin
      view[r.cnt[1:0]] = in_chunk;
      vcnt = r.cnt + `RXSB_FILL_W'(1);
    end
    // send when full, or on an idle cycle so nothing waits behind a gap
    flush = (vcnt == `RXSB_FILL_W'(`RXSB_SEG_COUNT)) || (!accept && r.cnt != '0);
    nxt.slots = view;
    nxt.cnt = flush ? '0 : vcnt;
  end

  // state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= RST_STATE;
    end else begin
      r <= nxt;
    end
  end

  assign pll_a_reset_output = r.rst_a[LOCK_W-1:0];
  assign pll_b_reset_output = r.rst_b[LOCK_W-1:0];
  assign rx_link_ready = r.ready;

  // ****************************************
  // output segments
  // ****************************************

  // each segment gets its own registered output stage
  for (genvar i = 0; i < `RXSB_SEG_COUNT; i++) begin : g_seg
    rxsb_seg_if sif ();
    assign sif.ena = flush && (`RXSB_FILL_W'(i) < vcnt);
    assign sif.chunk = view[i];
    rxsb_seg_format u_fmt (
      .clock(clock),
      .resetn(resetn),
      .link(sif.dst),
      .ena(rx_segment_valid_enable[i]),
      .data(rx_segment_data[i]),
      .first(rx_segment_first_flag[i]),
      .last(rx_segment_last_flag[i]),
      .error(rx_segment_error_flag[i]),
      .empty(rx_segment_empty_count[i])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  for (genvar k = 0; k < `RXSB_SEG_COUNT - 1; k++) begin : g_order
    a_fill_order: assert property (rx_segment_valid_enable[k + 1]
                                   |-> rx_segment_valid_enable[k])
      else $error("segment enabled above an empty lower segment");
  end

  a_full_flush: assert property ((accept && r.cnt == 3'h3) |=> (&rx_segment_valid_enable))
    else $error("four transfers did not leave together");

  a_idle_flush: assert property ((!accept && r.cnt != 3'h0) |=> rx_segment_valid_enable[0])
    else $error("pending transfers held over an idle cycle");

  a_quiet_hold: assert property ((r.pst == RXSB_PR_HOLD && r.cnt == 3'h0)
                                  |=> (rx_segment_valid_enable == 4'h0))
    else $error("segments enabled while pll held in reset");

  a_first_carry: assert property ((accept && in_first && r.cnt == 3'h3)
                                   |=> rx_segment_first_flag[3])
    else $error("first mark lost on segment three");

  a_last_carry: assert property ((accept && in_last && r.cnt == 3'h3)
                                  |=> rx_segment_last_flag[3] && rx_segment_valid_enable[3])
    else $error("last mark lost on segment three");

  a_error_empty: assert property ((accept && in_last && in_error && r.cnt == 3'h3)
                                   |=> rx_segment_error_flag[3]
                                       && rx_segment_empty_count[3][2:0] == 3'h0)
    else $error("errored packet end not marked correctly");

  a_pll_reassert: assert property ((r.pst == RXSB_PR_RUN && !lock_ok)
                                    |=> ##1 (PLL_SEL ? (|r.rst_b) : (|r.rst_a))
                                        && !rx_link_ready)
    else $error("pll reset not raised after lock loss");

  a_hold_length: assert property ($rose(r.pst == RXSB_PR_WAIT)
                                   |-> $past(r.pst == RXSB_PR_HOLD, HOLD_CYC))
    else $error("pll reset hold shorter than required");

  // the pll that is not in use must never see a reset pulse
  a_unsel_reset: assert property ((PLL_SEL ? pll_a_reset_output : pll_b_reset_output)
                                   == '0)
    else $error("unselected pll reset output raised");

endmodule

`default_nettype wire

// File: testbench/rxsb_user_sink.sv
// user logic model: consumes the four receive segments
// assumes it shares the block's clock and sees registered outputs
`timescale 1ns/1ps
`default_nettype none

module rxsb_user_sink (
  // clock
  input wire logic clock,
  // segmented user bus
  input wire rxsb_pkg::rxsb_data_t [3:0] data,
  input wire logic [3:0] ena,
  input wire logic [3:0] first,
  input wire logic [3:0] last,
  input wire logic [3:0] error,
  input wire rxsb_pkg::rxsb_empty_t [3:0] empty
);
  import rxsb_pkg::*;
  rxsb_chunk_t got_q[$];
  logic [1:0] idx_q[$];

  // lanes without enable are never read, the block drives their data to zero
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (ena[i] === 1'b1) begin
        got_q.push_back({data[i], first[i], last[i], error[i], empty[i]});
        idx_q.push_back(2'(i));
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/tb_rxsb_rx_bus.sv
// testbench of the receive segmented user bus
// assumes ten-lane build with pll a selected
`timescale 1ns/1ps
`default_nettype none
`include "rxsb_defines.svh"

module tb_rxsb_rx_bus;
  import rxsb_pkg::*;
  typedef struct packed {
    rxsb_chunk_t in_c;
    logic gap;
    rxsb_chunk_t exp;
  } rxsb_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic in_valid = 1'b0;
  rxsb_chunk_t in_c = '0;
  logic [2:0] lock_a = 3'h7;
  logic [2:0] lock_b = 3'h0;
  logic [9:0] pll_clk = 10'h0;
  logic [2:0] rst_a;
  logic [2:0] rst_b;
  logic rx_link_ready;
  rxsb_data_t [3:0] s_data;
  logic [3:0] s_ena, s_first, s_last, s_err;
  rxsb_empty_t [3:0] s_empty;
  int n_errors = 0;
  int compares = 0;
  int pos;
  rxsb_row_t rows[8];

  // ****************
  // clock and dut
  // ****************
  always #25 clock = ~clock;
  // shared logic outside keeps the pll clocks running free
  always #10 pll_clk = ~pll_clk;

  rxsb_rx_bus #(.TEN_LANE(1'b1), .PLL_SEL(1'b0)) dut (
    .clock(clock), .resetn(resetn), .in_valid(in_valid), .in_data(in_c.data),
    .in_first(in_c.first), .in_last(in_c.last), .in_error(in_c.error),
    .in_empty(in_c.empty), .pll_a_clock_input(pll_clk), .pll_a_reference_clock_input(pll_clk),
    .pll_b_clock_input(pll_clk), .pll_b_reference_clock_input(pll_clk),
    .pll_a_lock_input(lock_a), .pll_b_lock_input(lock_b), .pll_a_reset_output(rst_a),
    .pll_b_reset_output(rst_b), .rx_link_ready(rx_link_ready), .rx_segment_data(s_data),
    .rx_segment_valid_enable(s_ena), .rx_segment_first_flag(s_first),
    .rx_segment_last_flag(s_last), .rx_segment_error_flag(s_err),
    .rx_segment_empty_count(s_empty));

  rxsb_user_sink sink (
    .clock(clock), .data(s_data), .ena(s_ena), .first(s_first), .last(s_last),
    .error(s_err), .empty(s_empty));

  // ****************
  // helpers
  // ****************
  function automatic rxsb_chunk_t mk(input rxsb_data_t d, input logic [2:0] fle,
                                     input rxsb_empty_t e);
    mk = {d, fle, e};
  endfunction

  task automatic final_report();
    if (n_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_bits(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_chunk(input string n, input rxsb_chunk_t e, input rxsb_chunk_t g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // bounded wait; a hang ends the run instead of stalling it
  task automatic wait_ready();
    int k;
    k = 0;
    while (rx_link_ready !== 1'b1 && k < 80) begin
      @(negedge clock);
      k++;
    end
    if (rx_link_ready !== 1'b1) begin
      chk_bits("rx_link_ready", 8'h1, 8'(rx_link_ready));
      final_report();
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    // empty is cleared off last, low bits cleared on error
    rows = '{
      '{mk(128'hA1, 3'b100, 4'h0), 1'b0, mk(128'hA1, 3'b100, 4'h0)},
      '{mk(128'hA2, 3'b000, 4'h3), 1'b0, mk(128'hA2, 3'b000, 4'h0)},
      '{mk(128'hA3, 3'b001, 4'h0), 1'b0, mk(128'hA3, 3'b000, 4'h0)},
      '{mk(128'hA4, 3'b010, 4'h5), 1'b0, mk(128'hA4, 3'b010, 4'h5)},
      '{mk(128'hB1, 3'b100, 4'h0), 1'b0, mk(128'hB1, 3'b100, 4'h0)},
      '{mk(128'hB2, 3'b011, 4'hF), 1'b1, mk(128'hB2, 3'b011, 4'h8)},
      '{mk(128'hC1, 3'b110, 4'h7), 1'b1, mk(128'hC1, 3'b110, 4'h7)},
      '{mk(128'hD1, 3'b111, 4'hE), 1'b1, mk(128'hD1, 3'b111, 4'h8)}};
    repeat (8) @(posedge clock);
    chk_bits("pll_a_reset_output", 8'h7, 8'(rst_a));
    chk_bits("pll_b_reset_output", 8'h0, 8'(rst_b));
    chk_bits("valid_enable", 8'h0, 8'(s_ena));
    resetn <= 1'b1;
    // offers before the link is up must be dropped
    in_valid <= 1'b1;
    in_c <= rows[0].in_c;
    repeat (10) @(posedge clock);
    in_valid <= 1'b0;
    wait_ready();
    chk_bits("refused_count", 8'h0, 8'(sink.got_q.size()));
    @(posedge clock);
    foreach (rows[i]) begin
      in_valid <= 1'b1;
      in_c <= rows[i].in_c;
      @(posedge clock);
      if (rows[i].gap) begin
        in_valid <= 1'b0;
        @(posedge clock);
      end
    end
    in_valid <= 1'b0;
    repeat (6) @(posedge clock);
    chk_bits("segment_count", 8'h8, 8'(sink.got_q.size()));
    pos = 0;
    foreach (rows[i]) begin
      if (sink.got_q.size() > 0) begin
        chk_chunk("segment", rows[i].exp, sink.got_q.pop_front());
        chk_bits("segment_index", 8'(pos), 8'(sink.idx_q.pop_front()));
      end
      pos = (rows[i].gap || pos == 3) ? 0 : pos + 1;
    end
    // the unselected pll's lock comes and goes without touching the link
    lock_b <= 3'h7;
    repeat (4) @(posedge clock);
    lock_b <= 3'h0;
    repeat (4) @(posedge clock);
    chk_bits("ready_unselected_lock", 8'h1, 8'(rx_link_ready));
    chk_bits("pll_b_reset_output", 8'h0, 8'(rst_b));
    // lock loss must send the selected pll back into reset
    lock_a <= 3'h0;
    repeat (5) @(negedge clock);
    chk_bits("pll_a_reset_output", 8'h7, 8'(rst_a));
    chk_bits("rx_link_ready", 8'h0, 8'(rx_link_ready));
    @(posedge clock);
    lock_a <= 3'h7;
    wait_ready();
    // reset in mid-transfer: a held word never reaches the bus
    @(posedge clock);
    in_valid <= 1'b1;
    in_c <= rows[6].in_c;
    @(posedge clock);
    in_valid <= 1'b0;
    resetn <= 1'b0;
    repeat (3) @(negedge clock);
    chk_bits("valid_enable", 8'h0, 8'(s_ena));
    chk_bits("pll_b_reset_output", 8'h0, 8'(rst_b));
    @(posedge clock);
    resetn <= 1'b1;
    wait_ready();
    chk_bits("stale_count", 8'h0, 8'(sink.got_q.size()));
    final_report();
  end
endmodule

`default_nettype wire
